// ---- logic/fbp_flash_protect.sv ----
// flash array with block erase and per-region access protection
// assumes requests from fetch, data and debug paths on clk_sys, one at a time
`timescale 1ns/1ps

// What this block does
// - 128 KB flash reachable by processor and debugger
// - 1 KB blocks, each erased on its own
// - erased block reads back as all ones
// - one protection setting per 2 KB region
// - read-only region: reads ok, writes refused
// - execute-only: no writes, fetch reads only
// - execute-only blocks data and debugger reads
module fbp_flash_protect #(
    parameter int WORD_BITS = fbp_pkg::WORD_BITS,
    parameter int ERASE_WORDS = fbp_pkg::WORDS_PER_BLOCK
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // request
    input wire logic req_valid,
    input wire fbp_pkg::fbp_req_type req,
    output logic req_ready,
    // protection settings, two bits per region
    input wire fbp_pkg::fbp_prot_type [fbp_pkg::NUM_REGIONS-1:0] prot,
    // answer
    output fbp_pkg::fbp_rsp_type rsp
);
    // parameter checks
    if (WORD_BITS != fbp_pkg::WORD_BITS) begin : g_word_check
        $error("fbp_flash_protect: WORD_BITS must equal the flash word width");
    end
    if (ERASE_WORDS != fbp_pkg::WORDS_PER_BLOCK) begin : g_erase_check
        $error("fbp_flash_protect: ERASE_WORDS must equal the words of one block");
    end
    if (ERASE_WORDS != (1 << fbp_pkg::WOFF_BITS)) begin : g_offset_check
        $error("fbp_flash_protect: ERASE_WORDS must fill the word offset counter");
    end
    if (fbp_pkg::BLK_BITS + fbp_pkg::WOFF_BITS != fbp_pkg::WADDR_BITS) begin : g_index_check
        $error("fbp_flash_protect: block and offset must make up a word index");
    end
    if (fbp_pkg::REG_LSB != fbp_pkg::BLK_LSB + 1) begin : g_pair_check
        $error("fbp_flash_protect: a region must pair two erase blocks");
    end
    if (fbp_pkg::NUM_REGIONS != (1 << fbp_pkg::REG_BITS)) begin : g_region_check
        $error("fbp_flash_protect: region count must match the region index");
    end
    if ((1 << fbp_pkg::ADDR_BITS) != fbp_pkg::FLASH_BYTES) begin : g_size_check
        $error("fbp_flash_protect: byte address must span the whole array");
    end
    if (fbp_pkg::WORD_BYTES != (1 << fbp_pkg::WORD_LSB)) begin : g_lane_check
        $error("fbp_flash_protect: word index must skip the byte lanes");
    end
    if (fbp_pkg::ERASED_WORD != '1) begin : g_erased_check
        $error("fbp_flash_protect: erased word must be all ones");
    end

    typedef enum {
        FBP_IDLE,
        FBP_ERASING
    } fbp_state_type;

    logic [WORD_BITS-1:0] mem [fbp_pkg::WORDS];
    fbp_state_type state_r;
    logic [fbp_pkg::BLK_BITS-1:0] blk_r;
    logic [fbp_pkg::WOFF_BITS-1:0] woff_r;
    logic ready_r;
    logic done_r;
    logic denied_r;
    logic [WORD_BITS-1:0] rdata_r;
    logic allow;
    logic [fbp_pkg::WADDR_BITS-1:0] waddr;
    logic [fbp_pkg::WADDR_BITS-1:0] sweep_addr;
    logic [fbp_pkg::REG_BITS-1:0] region;
    logic take;
    logic is_read;
    logic is_program;
    logic is_erase;
    logic start_erase;
    logic erase_last;
    logic sweep_end;

    // word index of a byte address
    function automatic logic [fbp_pkg::WADDR_BITS-1:0] fbp_word_of(
            logic [fbp_pkg::ADDR_BITS-1:0] a);
        return a[fbp_pkg::ADDR_BITS-1:fbp_pkg::WORD_LSB];
    endfunction

    // erase block of a byte address
    function automatic logic [fbp_pkg::BLK_BITS-1:0] fbp_block_of(
            logic [fbp_pkg::ADDR_BITS-1:0] a);
        return a[fbp_pkg::ADDR_BITS-1:fbp_pkg::BLK_LSB];
    endfunction

    // protection region of a byte address, two blocks wide
    function automatic logic [fbp_pkg::REG_BITS-1:0] fbp_region_of(
            logic [fbp_pkg::ADDR_BITS-1:0] a);
        return a[fbp_pkg::ADDR_BITS-1:fbp_pkg::REG_LSB];
    endfunction

    // protection decision for one access
    function automatic logic fbp_allowed(fbp_pkg::fbp_prot_type p, fbp_pkg::fbp_src_type s,
                                         fbp_pkg::fbp_op_type o);
        logic ok;
        ok = 1'b0;
        unique case (p)
            fbp_pkg::FBP_PROT_NONE: ok = 1'b1;
            fbp_pkg::FBP_PROT_READ_ONLY: ok = (o == fbp_pkg::FBP_OP_READ);
            fbp_pkg::FBP_PROT_EXEC_ONLY: ok = (o == fbp_pkg::FBP_OP_READ) &&
                                              (s == fbp_pkg::FBP_SRC_FETCH);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // request decode
    assign waddr = fbp_word_of(req.addr);
    assign region = fbp_region_of(req.addr);
    assign allow = fbp_allowed(prot[region], req.src, req.op);
    assign take = req_valid && ready_r;
    assign is_read = (req.op == fbp_pkg::FBP_OP_READ);
    assign is_program = (req.op == fbp_pkg::FBP_OP_PROGRAM);
    assign is_erase = (req.op == fbp_pkg::FBP_OP_ERASE);
    assign start_erase = take && allow && is_erase;
    assign sweep_addr = {blk_r, woff_r};
    assign erase_last = (woff_r == fbp_pkg::WOFF_BITS'(ERASE_WORDS - 1));
    assign sweep_end = (state_r == FBP_ERASING) && erase_last;

    // erase sequencer state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= FBP_IDLE;
        end else begin
            unique case (state_r)
                FBP_IDLE: begin
                    if (start_erase) begin
                        state_r <= FBP_ERASING;
                    end
                end
                FBP_ERASING: begin
                    if (erase_last) begin
                        state_r <= FBP_IDLE;
                    end
                end
            endcase
        end
    end

    // block under erase, latched at the request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            blk_r <= '0;
        end else if (start_erase) begin
            blk_r <= fbp_block_of(req.addr);
        end
    end

    // word offset of the erase sweep
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            woff_r <= '0;
        end else if (start_erase) begin
            woff_r <= '0;
        end else if (state_r == FBP_ERASING) begin
            woff_r <= woff_r + 1'h1;
        end
    end

    // array writes: program word or erase sweep
    always_ff @(posedge clk_sys) begin
        if (state_r == FBP_ERASING) begin
            mem[sweep_addr] <= fbp_pkg::ERASED_WORD;
        end else if (take && allow && is_program) begin
            mem[waddr] <= mem[waddr] & req.wdata;
        end
    end

    // ready: low for the whole erase sweep
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ready_r <= 1'h1;
        end else if (start_erase) begin
            ready_r <= 1'h0;
        end else if (sweep_end) begin
            ready_r <= 1'h1;
        end
    end

    // done: one-cycle pulse for every answer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'h0;
        end else begin
            done_r <= sweep_end || (take && !start_erase);
        end
    end

    // denied: held until the next request is taken
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            denied_r <= 1'h0;
        end else if (sweep_end) begin
            denied_r <= 1'h0;
        end else if (take) begin
            denied_r <= !allow;
        end
    end

    // read data: array word for an allowed read, else zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else if (take) begin
            if (allow && is_read) begin
                rdata_r <= mem[waddr];
            end else begin
                rdata_r <= '0;
            end
        end
    end

    // outputs straight from the registers
    assign req_ready = ready_r;
    assign rsp = {done_r, denied_r, rdata_r};
endmodule // fbp_flash_protect

// ---- logic/fbp_pkg.sv ----
// constants and carriers for the flash block protection logic
// assumes a single 50 MHz clock domain and word-wide flash access
package fbp_pkg;
    localparam int FLASH_BYTES = 131072;
    localparam int BLOCK_BYTES = 1024;
    localparam int REGION_BYTES = 2048;
    localparam int WORD_BYTES = 4;
    localparam int WORD_BITS = 32;
    localparam int ADDR_BITS = 17;
    localparam int WORDS = FLASH_BYTES / WORD_BYTES;
    localparam int WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
    localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
    localparam int NUM_REGIONS = FLASH_BYTES / REGION_BYTES;
    localparam int WADDR_BITS = ADDR_BITS - 2;
    localparam int BLK_BITS = 7;
    localparam int WOFF_BITS = 8;
    localparam int REG_LSB = 11;
    localparam int REG_BITS = 6;
    localparam int WORD_LSB = 2;
    localparam int BLK_LSB = 10;
    localparam int CLK_MHZ = 50;
    localparam logic [WORD_BITS-1:0] ERASED_WORD = 32'hFFFF_FFFF;

    // access sources
    typedef enum logic [1:0] {
        FBP_SRC_FETCH,
        FBP_SRC_DATA,
        FBP_SRC_DEBUG
    } fbp_src_type;

    // operations
    typedef enum logic [1:0] {
        FBP_OP_READ,
        FBP_OP_PROGRAM,
        FBP_OP_ERASE
    } fbp_op_type;

    // per-region protection marking
    typedef enum logic [1:0] {
        FBP_PROT_NONE,
        FBP_PROT_READ_ONLY,
        FBP_PROT_EXEC_ONLY
    } fbp_prot_type;

    typedef struct packed {
        fbp_src_type src;
        fbp_op_type op;
        logic [ADDR_BITS-1:0] addr;
        logic [WORD_BITS-1:0] wdata;
    } fbp_req_type;

    typedef struct packed {
        logic done;
        logic denied;
        logic [WORD_BITS-1:0] rdata;
    } fbp_rsp_type;
endpackage

// ---- verif/fbp_monitor.sv ----
// checker on the flash protection ports
// assumes bind from tb
`timescale 1ns/1ps
module fbp_monitor (
    // watched ports
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic req_valid,
    input wire fbp_pkg::fbp_req_type req,
    input wire logic req_ready,
    input wire fbp_pkg::fbp_prot_type [63:0] prot,
    input wire fbp_pkg::fbp_rsp_type rsp
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire [1:0] p = prot[req.addr[16:11]];
    wire t = req_valid && req_ready;
    wire rd = t && req.op == 2'h0;
    wire er = t && req.op == 2'h2;
    chk_read_answers: assert property (rd |=> rsp.done) else $error("no read");
    chk_ro_writes: assert property (t && !rd && p == 1 |=> rsp.denied) else $error("ro wr");
    chk_ro_reads: assert property (rd && p == 1 |=> !rsp.denied) else $error("ro rd");
    chk_xo_fetch: assert property (rd && p == 2 && req.src == 0 |=> !rsp.denied)
        else $error("xo fetch");
    chk_xo_block: assert property (t && p == 2 && !(rd && req.src == 0) |=> rsp.denied)
        else $error("xo taken");
    chk_open_access: assert property (t && !er && p == 0 |=> !rsp.denied)
        else $error("open denied");
    chk_erase_busy: assert property (er && p == 0 |=> !req_ready [*8]) else $error("busy");
    chk_erase_done: assert property (er && p == 0 |-> ##257 (rsp.done && req_ready))
        else $error("erase late");
endmodule // fbp_monitor

// ---- verif/fbp_requester.sv ----
// requester model for fetch, data and debug paths
// assumes an answer within 300 cycles
`timescale 1ns/1ps
module fbp_requester (
    // request port
    input wire logic clk_sys,
    output logic req_valid,
    output fbp_pkg::fbp_req_type req,
    input wire logic req_ready,
    input wire fbp_pkg::fbp_rsp_type rsp
);
    initial {req_valid, req} = '0;
    task automatic access(input fbp_pkg::fbp_req_type q, output fbp_pkg::fbp_rsp_type r);
        int n = 0;
        @(posedge clk_sys) #1;
        {req_valid, req} = {1'b1, q};
        do @(posedge clk_sys); while (!req_ready && ++n < 300);
        #1 {req_valid, req} = {1'b0, ~q};
        for (n = 0; n < 300 && !rsp.done; n++) @(posedge clk_sys) #1;
        r = rsp;
    endtask
endmodule // fbp_requester

// ---- verif/tb.sv ----
// bench: erase, program, protected access
// assumes requester model and bound checker
`timescale 1ns/1ps
module tb;
    localparam logic [32:0] deny = 33'h1_0000_0000;
    localparam logic [32:0] ones = {1'b0, 32'hFFFF_FFFF};
    localparam logic [32:0] kept = {1'b0, 32'hA5A5_000F};
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic req_valid, req_ready;
    fbp_pkg::fbp_req_type req;
    fbp_pkg::fbp_prot_type [63:0] prot = '0;
    fbp_pkg::fbp_rsp_type rsp, r;
    int err_count = 0;
    int check_count = 0;
    always #10 clk_sys = ~clk_sys;
    fbp_flash_protect DUT (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .prot(prot), .rsp(rsp));
    fbp_requester u_req (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp(rsp));
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // so is {src, op}, exp is {denied, rdata}
    task automatic acc(input logic [3:0] so, input logic [16:0] a, input logic [31:0] d,
            input logic [32:0] exp);
        u_req.access({so, a, d}, r);
        chk(33'(r.done), 33'h1);
        if (r.done !== 1'b1) stop_test();
        chk({r.denied, r.rdata}, exp);
    endtask
    task automatic t_erase();
        for (int b = 125; b < 128; b++) begin
            acc(4'h6, 17'(b << 10), '0, '0);
            acc(4'h4, 17'(b << 10) + 17'h3FC, '0, ones);
        end
    endtask
    task automatic t_program();
        acc(4'h5, 17'h1_FC04, 32'hA5A5_0F0F, '0);
        acc(4'h5, 17'h1_FC04, 32'hFFFF_00FF, '0);
        acc(4'h6, 17'h1_F800, '0, '0);
        acc(4'h8, 17'h1_FC04, '0, kept);
    endtask
    task automatic t_protect();
        prot[63] = fbp_pkg::FBP_PROT_READ_ONLY;
        acc(4'h5, 17'h1_FC04, '0, deny);
        acc(4'h6, 17'h1_FC00, '0, deny);
        acc(4'h4, 17'h1_FC04, '0, kept);
        prot[63] = fbp_pkg::FBP_PROT_EXEC_ONLY;
        for (int s = 0; s < 3; s++)
            acc({2'(s), 2'h0}, 17'h1_FC04, '0, s ? deny : kept);
        acc(4'h5, 17'h1_FC04, '0, deny);
        acc(4'h6, 17'h1_FC00, '0, deny);
        acc(4'h4, 17'h1_F7FC, '0, ones);
        prot[63] = fbp_pkg::FBP_PROT_NONE;
        acc(4'h0, 17'h1_FC04, '0, kept);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 nrst = 1'b1;
        t_erase();
        t_program();
        t_protect();
        stop_test();
    end
endmodule // tb
bind fbp_flash_protect fbp_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .prot(prot), .rsp(rsp));
